// file: bit_error_defs.svh
// Register offsets, field positions, reset values and timing counts of the bit error counter.
`ifndef BIT_ERROR_DEFS_SVH
`define BIT_ERROR_DEFS_SVH

// Register byte offsets.
`define REG_CTRL_OFS 8'h00
`define REG_CMD_OFS 8'h04
`define REG_STATUS_OFS 8'h08
`define REG_IRQ_STAT_OFS 8'h0C
`define REG_IRQ_MASK_OFS 8'h10

// Control register fields.
`define CTRL_MODE_BIT 0
`define CTRL_AUTO_BIT 1
`define CTRL_WIN_LSB 4
`define CTRL_RESET 8'h00

// Command register fields, write-only strobes.
`define CMD_CLEAR_BIT 0
`define CMD_SYNC_BIT 1

// Status register fields.
`define STAT_COUNT_LSB 0
`define STAT_OVF_BIT 8
`define STAT_COMP_BIT 9
`define STAT_ALIGNED_BIT 10
`define STAT_STATE_LSB 12

// Interrupt status and mask fields.
`define IRQ_ERR_BIT 0
`define IRQ_OVF_BIT 1
`define IRQ_COMP_BIT 2
`define IRQ_MASK_RESET 3'h0

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Counting limits and reference pattern shape.
`define OVERFLOW_LIMIT 50
`define PRBS_LEN 9
`define PRBS_TAP 5

// Timing: auto clear delay and clock rate.
`define AUTO_CLEAR_MS 5000
`define CLK_KHZ 40000
`define AUTO_CLEAR_CYCLES (`AUTO_CLEAR_MS * `CLK_KHZ)

`endif

// file: bit_error_pkg.sv
// Types shared by the bit error counter and its reference pattern generator.
package bit_error_pkg;

   typedef enum logic {
      reversal_check_mode = 1'b0,
      pseudorandom_check_mode = 1'b1
   } check_mode_t;

   // Gray coded along sync -> count -> done.
   typedef enum logic [1:0] {
      ST_SYNC = 2'b00,
      ST_COUNT = 2'b01,
      ST_DONE = 2'b11
   } meas_state_t;

   typedef struct packed {
      logic [2:0] error_window_length;
      logic auto_clear;
      check_mode_t mode;
   } ctrl_t;

   typedef struct packed {
      logic pulse;
      logic err;
   } cmp_t;

endpackage

// file: pattern_reference.sv
// Reference pattern generator and bit comparator for reversal and pseudorandom checking.
`timescale 1ns/100ps
`default_nettype none
`include "bit_error_defs.svh"

module pattern_reference import bit_error_pkg::*; #(
   parameter int PRBS_LEN = `PRBS_LEN,
   parameter int PRBS_TAP = `PRBS_TAP
) (
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // Received stream
   input wire logic bit_strobe,
   input wire logic rx_bit,
   // Control
   input wire check_mode_t mode,
   input wire logic sync_request,
   // Result
   output logic aligned,
   output cmp_t cmp
);

   localparam int FILL_W = $clog2(PRBS_LEN + 1);

   generate
      if (PRBS_TAP < 1 || PRBS_TAP >= PRBS_LEN || PRBS_LEN < 2) begin : g_bad_prbs
         $error("pattern_reference: tap must lie inside the shift register");
      end
   endgenerate

   logic [PRBS_LEN-1:0] lfsr_q;
   logic rev_q;
   logic [FILL_W-1:0] fill_q;
   logic aligned_q;
   cmp_t cmp_q;

   wire prbs_expect = lfsr_q[PRBS_LEN-1] ^ lfsr_q[PRBS_TAP-1];
   wire expected = (mode == pseudorandom_check_mode) ? prbs_expect : rev_q;
   wire filling = (fill_q != '0);
   // Reversal needs one bit to learn its phase, the sequence needs a full register.
   wire [FILL_W-1:0] fill_start = (mode == pseudorandom_check_mode) ? FILL_W'(PRBS_LEN) : FILL_W'(1);

   ////////////////////////////////////////////////////////////////////////////
   // Alignment and comparison. While aligning, the reference is loaded from the
   // line; afterwards it runs free so that a line error does not echo through it.

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lfsr_q <= '0;
         rev_q <= 1'b0;
         fill_q <= '0;
         aligned_q <= 1'b0;
         cmp_q <= '0;
      end else if (clk_en) begin
         cmp_q <= '0;
         if (sync_request) begin
            fill_q <= fill_start;
            aligned_q <= 1'b0;
         end else if (bit_strobe && filling) begin
            lfsr_q <= {lfsr_q[PRBS_LEN-2:0], rx_bit};
            rev_q <= ~rx_bit;
            fill_q <= fill_q - FILL_W'(1);
            aligned_q <= (fill_q == FILL_W'(1));
         end else if (bit_strobe && aligned_q) begin
            lfsr_q <= {lfsr_q[PRBS_LEN-2:0], expected};
            rev_q <= ~rev_q;
            cmp_q.pulse <= 1'b1;
            cmp_q.err <= (rx_bit != expected);
         end
      end
   end

   assign aligned = aligned_q;
   assign cmp = cmp_q;

endmodule // pattern_reference

`default_nettype wire

// file: bit_error_counter.sv
// Bit error counter with measurement window, overflow, auto clear and AXI4-Lite registers.
//
// Summary of operation
// - Reversal mode: count each bit disagreeing with reference.
// - Overflow at fifty errors, held until clear.
// - Manual clear drops overflow, complete, zeroes count.
// - Thousand-bit window raises count-complete at end.
// - Auto clear five seconds after count-complete.
// - Pseudorandom mode counts against sequence, same behaviour.
`timescale 1ns/100ps
`default_nettype none
`include "bit_error_defs.svh"

module bit_error_counter import bit_error_pkg::*; #(
   parameter int ADDR_W = 8,
   parameter int CNT_W = 6,
   parameter int OVF_LIMIT = `OVERFLOW_LIMIT,
   parameter int WIN_W = 20,
   parameter int TIMER_W = 28,
   parameter int unsigned AUTO_CLEAR_CYCLES = `AUTO_CLEAR_CYCLES
) (
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // Received bit stream, one strobe per bit period
   input wire logic bit_strobe,
   input wire logic rx_bit,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Indications
   output logic [CNT_W-1:0] error_count,
   output logic overflow,
   output logic count_complete,
   output logic irq
);

   generate
      if (OVF_LIMIT < 1 || OVF_LIMIT >= (1 << CNT_W)) begin : g_bad_cnt
         $error("bit_error_counter: overflow limit does not fit the count");
      end
      if (WIN_W < 20) begin : g_bad_win
         $error("bit_error_counter: window counter too narrow for a million bits");
      end
      if (AUTO_CLEAR_CYCLES < 1 || AUTO_CLEAR_CYCLES > (64'd1 << TIMER_W)) begin : g_bad_timer
         $error("bit_error_counter: auto clear delay does not fit the timer");
      end
      if (ADDR_W < 5) begin : g_bad_addr
         $error("bit_error_counter: address too narrow for the register map");
      end
   endgenerate

   // Window length in bit periods for each setting; zero stands for infinite.
   function automatic logic [WIN_W-1:0] window_bits(input logic [2:0] sel);
      case (sel)
         3'h1: window_bits = WIN_W'(32'h0000_000A);
         3'h2: window_bits = WIN_W'(32'h0000_0064);
         3'h3: window_bits = WIN_W'(32'h0000_03E8);
         3'h4: window_bits = WIN_W'(32'h0000_2710);
         3'h5: window_bits = WIN_W'(32'h0001_86A0);
         3'h6: window_bits = WIN_W'(32'h000F_4240);
         default: window_bits = '0;
      endcase
   endfunction

   ctrl_t ctrl_q;
   meas_state_t state_q, state_d;
   logic [CNT_W-1:0] count_q;
   logic overflow_q;
   logic complete_q;
   logic [WIN_W-1:0] win_q;
   logic [TIMER_W-1:0] timer_q;
   logic [2:0] irq_stat_q;
   logic [2:0] irq_mask_q;
   logic aligned;
   cmp_t cmp;

   logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;

   ////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data are taken in either order and the write
   // lands when both are present. Only one response is outstanding at a time.

   assign awready = !aw_held_q && !bvalid_q;
   assign wready = !w_held_q && !bvalid_q;
   wire aw_take = awvalid && awready;
   wire w_take = wvalid && wready;
   wire wr_fire = (aw_held_q || aw_take) && (w_held_q || w_take) && !bvalid_q;
   wire [ADDR_W-1:0] wr_addr = aw_held_q ? awaddr_q : awaddr;
   wire [31:0] wr_data = w_held_q ? wdata_q : wdata;
   wire [3:0] wr_strb = w_held_q ? wstrb_q : wstrb;
   wire wr_lane0 = wr_fire && wr_strb[0];

   wire wr_is_ctrl = (wr_addr == ADDR_W'(`REG_CTRL_OFS));
   wire wr_is_cmd = (wr_addr == ADDR_W'(`REG_CMD_OFS));
   wire wr_is_stat = (wr_addr == ADDR_W'(`REG_STATUS_OFS));
   wire wr_is_istat = (wr_addr == ADDR_W'(`REG_IRQ_STAT_OFS));
   wire wr_is_imask = (wr_addr == ADDR_W'(`REG_IRQ_MASK_OFS));
   wire wr_hit = wr_is_ctrl || wr_is_cmd || wr_is_stat || wr_is_istat || wr_is_imask;

   wire manual_clear = wr_lane0 && wr_is_cmd && wr_data[`CMD_CLEAR_BIT];
   wire sync_request_button = wr_lane0 && wr_is_cmd && wr_data[`CMD_SYNC_BIT];
   wire [2:0] irq_w1c = (wr_lane0 && wr_is_istat) ? wr_data[2:0] : 3'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (clk_en) begin
         aw_held_q <= (aw_held_q || aw_take) && !wr_fire;
         w_held_q <= (w_held_q || w_take) && !wr_fire;
         if (aw_take) awaddr_q <= awaddr;
         if (w_take) wdata_q <= wdata;
         if (w_take) wstrb_q <= wstrb;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end else if (clk_en) begin
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign bvalid = bvalid_q;
   assign bresp = bresp_q;

   ////////////////////////////////////////////////////////////////////////////
   // Read channel: one cycle from address to data.

   wire [31:0] stat_word = (32'(count_q) << `STAT_COUNT_LSB) | (32'(overflow_q) << `STAT_OVF_BIT)
      | (32'(complete_q) << `STAT_COMP_BIT) | (32'(aligned) << `STAT_ALIGNED_BIT)
      | (32'(state_q) << `STAT_STATE_LSB);
   wire [31:0] ctrl_word = (32'(ctrl_q.mode) << `CTRL_MODE_BIT) | (32'(ctrl_q.auto_clear) << `CTRL_AUTO_BIT)
      | (32'(ctrl_q.error_window_length) << `CTRL_WIN_LSB);
   wire rd_is_ctrl = (araddr == ADDR_W'(`REG_CTRL_OFS));
   wire rd_is_cmd = (araddr == ADDR_W'(`REG_CMD_OFS));
   wire rd_is_stat = (araddr == ADDR_W'(`REG_STATUS_OFS));
   wire rd_is_istat = (araddr == ADDR_W'(`REG_IRQ_STAT_OFS));
   wire rd_is_imask = (araddr == ADDR_W'(`REG_IRQ_MASK_OFS));
   wire rd_hit = rd_is_ctrl || rd_is_cmd || rd_is_stat || rd_is_istat || rd_is_imask;
   wire [31:0] rd_word = rd_is_ctrl ? ctrl_word : rd_is_stat ? stat_word
      : rd_is_istat ? 32'(irq_stat_q) : rd_is_imask ? 32'(irq_mask_q) : 32'h0000_0000;

   assign arready = !rvalid_q;
   wire ar_take = arvalid && arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= `RESP_OKAY;
      end else if (clk_en) begin
         if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   ////////////////////////////////////////////////////////////////////////////
   // Control and interrupt registers.

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= ctrl_t'(5'(`CTRL_RESET));
         irq_mask_q <= `IRQ_MASK_RESET;
      end else if (clk_en) begin
         if (wr_lane0 && wr_is_ctrl) begin
            ctrl_q.mode <= check_mode_t'(wr_data[`CTRL_MODE_BIT]);
            ctrl_q.auto_clear <= wr_data[`CTRL_AUTO_BIT];
            ctrl_q.error_window_length <= wr_data[`CTRL_WIN_LSB +: 3];
         end
         if (wr_lane0 && wr_is_imask) irq_mask_q <= wr_data[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference pattern and comparison.

   pattern_reference #(
      .PRBS_LEN(`PRBS_LEN),
      .PRBS_TAP(`PRBS_TAP)
   ) u_reference (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .bit_strobe(bit_strobe),
      .rx_bit(rx_bit),
      .mode(ctrl_q.mode),
      .sync_request(sync_request_button),
      .aligned(aligned),
      .cmp(cmp)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Measurement sequence. Bits are only judged once the reference is aligned.

   wire [WIN_W-1:0] win_target = window_bits(ctrl_q.error_window_length);
   wire counting = (state_q == ST_COUNT);
   wire bit_seen = counting && cmp.pulse;
   wire err_seen = bit_seen && cmp.err;
   wire window_end = bit_seen && (win_target != '0) && (win_q == win_target - WIN_W'(1));
   wire auto_expire = (state_q == ST_DONE) && ctrl_q.auto_clear
      && (timer_q == TIMER_W'(AUTO_CLEAR_CYCLES - 1));
   wire clear_now = manual_clear || auto_expire;
   wire ovf_hit = err_seen && (count_q == CNT_W'(OVF_LIMIT - 1));

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_SYNC: if (aligned) state_d = ST_COUNT;
         ST_COUNT: if (window_end) state_d = ST_DONE;
         ST_DONE: if (clear_now) state_d = ST_COUNT;
         default: state_d = ST_SYNC;
      endcase
      if (sync_request_button) state_d = ST_SYNC;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) state_q <= ST_SYNC;
      else if (clk_en) state_q <= state_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= '0;
         overflow_q <= 1'b0;
         complete_q <= 1'b0;
      end else if (clk_en) begin
         if (clear_now) begin
            count_q <= '0;
            overflow_q <= 1'b0;
            complete_q <= 1'b0;
         end else begin
            // The count stops at the limit so the meter never wraps.
            if (err_seen && count_q != CNT_W'(OVF_LIMIT)) count_q <= count_q + CNT_W'(1);
            if (ovf_hit) overflow_q <= 1'b1;
            if (window_end) complete_q <= 1'b1;
         end
      end
   end

   // A new window starts after every clear and every realignment.
   always_ff @(posedge aclk) begin
      if (!aresetn) win_q <= '0;
      else if (clk_en) begin
         if (clear_now || !counting) win_q <= '0;
         else if (bit_seen) win_q <= win_q + WIN_W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) timer_q <= '0;
      else if (clk_en) begin
         if (state_q == ST_DONE && ctrl_q.auto_clear && !clear_now) timer_q <= timer_q + TIMER_W'(1);
         else timer_q <= '0;
      end
   end

   // Hardware set wins over a software clear in the same cycle.
   wire [2:0] irq_events = {window_end, ovf_hit, err_seen};

   always_ff @(posedge aclk) begin
      if (!aresetn) irq_stat_q <= 3'h0;
      else if (clk_en) irq_stat_q <= (irq_stat_q & ~irq_w1c) | irq_events;
   end

   assign irq = |(irq_stat_q & irq_mask_q);
   assign error_count = count_q;
   assign overflow = overflow_q;
   assign count_complete = complete_q;

endmodule // bit_error_counter

`default_nettype wire

// file: bit_error_counter_props.sv
// Concurrent checks on the indication outputs of the bit error counter.
`timescale 1ns/100ps
`default_nettype none

module bit_error_counter_props #(
   parameter int CNT_W = 6,
   parameter int OVF_LIMIT = 50
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Stream and indications
   input wire logic bit_strobe,
   input wire logic [CNT_W-1:0] error_count,
   input wire logic overflow,
   input wire logic count_complete
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_count_step;
      error_count != $past(error_count) |-> error_count == $past(error_count) + 1'b1 || error_count == '0;
   endproperty
   a_count_step: assert property (p_count_step) else $error("error count moved by more than one");

   // A judged bit lands in the count two edges after its strobe.
   property p_count_cause;
      error_count == $past(error_count) + 1'b1 |-> $past(bit_strobe, 2);
   endproperty
   a_count_cause: assert property (p_count_cause) else $error("count rose without a strobed bit");

   property p_ovf_rise;
      $rose(overflow) |-> error_count == OVF_LIMIT;
   endproperty
   a_ovf_rise: assert property (p_ovf_rise) else $error("overflow rose away from the limit");

   property p_ovf_at_limit;
      error_count == OVF_LIMIT |-> overflow;
   endproperty
   a_ovf_at_limit: assert property (p_ovf_at_limit) else $error("limit reached without overflow");

   property p_ovf_sticky;
      overflow |=> overflow || error_count == '0;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow dropped without a clear");

   property p_ovf_drop;
      $fell(overflow) |-> error_count == '0 && !count_complete;
   endproperty
   a_ovf_drop: assert property (p_ovf_drop) else $error("overflow dropped but display not cleared");

   property p_complete_frozen;
      count_complete && $past(count_complete) |-> error_count == $past(error_count);
   endproperty
   a_complete_frozen: assert property (p_complete_frozen) else $error("count moved after completion");

   property p_complete_drop;
      $fell(count_complete) |-> error_count == '0 && !overflow;
   endproperty
   a_complete_drop: assert property (p_complete_drop) else $error("completion dropped without clearing count");

   c_complete: cover property ($rose(count_complete));
endmodule // bit_error_counter_props

bind bit_error_counter bit_error_counter_props #(.CNT_W(CNT_W), .OVF_LIMIT(OVF_LIMIT)) bit_error_counter_props_inst (
   .aclk(aclk),
   .aresetn(aresetn),
   .bit_strobe(bit_strobe),
   .error_count(error_count),
   .overflow(overflow),
   .count_complete(count_complete)
);

`default_nettype wire

// file: pattern_source.sv
// Model of the external pattern source driving the received serial line.
`timescale 1ns/100ps
`default_nettype none

module pattern_source import bit_error_pkg::*; #(
   parameter int PERIOD = 4
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pattern selection and error injection
   input wire check_mode_t mode,
   input wire logic flip_req,
   // Serial line
   output logic bit_strobe,
   output logic rx_bit
);
   logic [8:0] lfsr_q;
   logic rev_q;
   logic flip_q;
   logic last_q;
   logic [7:0] div_q;
   logic next_bit;

   assign next_bit = (mode == pseudorandom_check_mode) ? (lfsr_q[8] ^ lfsr_q[4]) : rev_q;
   // Outside the strobe cycle the line shows the inverse, so sampling off the strobe is caught.
   assign rx_bit = bit_strobe ? last_q : ~last_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lfsr_q <= 9'h0A5;
         rev_q <= 1'b1;
         flip_q <= 1'b0;
         last_q <= 1'b0;
         div_q <= 8'h00;
         bit_strobe <= 1'b0;
      end else begin
         bit_strobe <= 1'b0;
         div_q <= div_q + 8'h01;
         if (div_q == 8'(PERIOD - 1)) begin
            div_q <= 8'h00;
            bit_strobe <= 1'b1;
            last_q <= next_bit ^ flip_q;
            flip_q <= 1'b0;
            rev_q <= ~rev_q;
            lfsr_q <= {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
         end
         if (flip_req) begin
            flip_q <= 1'b1;
         end
      end
   end
endmodule // pattern_source

`default_nettype wire

// file: bit_error_counter_tb.sv
// Self-checking testbench of the bit error counter with a pattern source model.
`timescale 1ns/100ps
`default_nettype none
`include "bit_error_defs.svh"

module bit_error_counter_tb import bit_error_pkg::*;;
   localparam int PER = 4;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic clk_en = 1'b1;
   logic bit_strobe, rx_bit, flip_req = 1'b0;
   check_mode_t mode = reversal_check_mode;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, overflow, count_complete, irq;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [2:0] awprot = 3'h0, arprot = 3'h0;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [3:0] wstrb = 4'h1;
   logic [1:0] bresp, rresp;
   logic [5:0] error_count;
   logic [1:0] bq[$];
   logic [33:0] rq[$];
   logic [33:0] rnote;
   int err_count = 0, comparisons = 0, strobes = 0, base = 0;

   always #12.5 aclk = ~aclk;

   bit_error_counter #(.AUTO_CLEAR_CYCLES(20)) bit_error_counter_inst (
      .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .bit_strobe(bit_strobe), .rx_bit(rx_bit),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .error_count(error_count), .overflow(overflow), .count_complete(count_complete), .irq(irq)
   );

   pattern_source #(.PERIOD(PER)) pattern_source_inst (
      .aclk(aclk), .aresetn(aresetn), .mode(mode), .flip_req(flip_req),
      .bit_strobe(bit_strobe), .rx_bit(rx_bit)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Bus master; the leading edge keeps a new request off the edge that ended the last.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n = 0;
      @(posedge aclk);
      bq.push_back(r);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (n >= 0 && n < 200) begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            n = -1;
         end
      end
      if (n >= 0) err_count++;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n = 0;
      @(posedge aclk);
      rq.push_back({d, r});
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      while (n >= 0 && n < 200) begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            n = -1;
         end
      end
      if (n >= 0) err_count++;
   endtask

   always @(posedge aclk) begin
      if (bvalid && bready) check({30'h0, bresp}, {30'h0, bq.pop_front()});
      if (rvalid && rready) begin
         rnote = rq.pop_front();
         check(rdata, rnote[33:2]);
         check({30'h0, rresp}, {30'h0, rnote[1:0]});
      end
      if (bit_strobe) strobes <= strobes + 1;
   end

   task automatic flip(input int n);
      repeat (n) begin
         @(posedge aclk);
         flip_req <= 1'b1;
         @(posedge aclk);
         flip_req <= 1'b0;
         repeat (2 * PER) @(posedge aclk);
      end
      repeat (3 * PER) @(posedge aclk);
   endtask

   task automatic sync_clear;
      wr(`REG_CMD_OFS, 32'h0000_0002, `RESP_OKAY);
      repeat (12) @(posedge aclk iff bit_strobe);
      wr(`REG_CMD_OFS, 32'h0000_0001, `RESP_OKAY);
      base = strobes;
      rd(`REG_STATUS_OFS, 32'h0000_1400, `RESP_OKAY);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int e, n, k;
      void'($urandom(24));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check({23'h0, error_count, overflow, count_complete, irq}, 32'h0000_0000);
      rd(`REG_CTRL_OFS, 32'h0000_0000, `RESP_OKAY);
      rd(`REG_IRQ_MASK_OFS, 32'h0000_0000, `RESP_OKAY);
      rd(`REG_STATUS_OFS, 32'h0000_0000, `RESP_OKAY);
      rd(8'h14, 32'h0000_0000, `RESP_SLVERR);
      wr(8'h14, 32'h0000_00FF, `RESP_SLVERR);
      wr(`REG_IRQ_MASK_OFS, 32'h0000_0002, `RESP_OKAY);
      rd(`REG_IRQ_MASK_OFS, 32'h0000_0002, `RESP_OKAY);
      $display("test registers done");

      sync_clear();
      flip(5);
      check({26'h0, error_count}, 32'd5);
      check({31'h0, irq}, 32'h0000_0000);
      // An even number of missed strobes keeps the reversal phase, and the flipped bit is never seen.
      @(posedge aclk);
      clk_en <= 1'b0;
      flip_req <= 1'b1;
      @(posedge aclk);
      flip_req <= 1'b0;
      repeat (4 * PER - 1) @(posedge aclk);
      clk_en <= 1'b1;
      repeat (3 * PER) @(posedge aclk);
      check({26'h0, error_count}, 32'd5);
      flip(45);
      check({26'h0, error_count}, 32'd50);
      check({30'h0, overflow, irq}, 32'h0000_0003);
      flip(3);
      check({26'h0, error_count}, 32'd50);
      check({31'h0, overflow}, 32'h0000_0001);
      repeat (1100 * PER) @(posedge aclk);
      check({31'h0, count_complete}, 32'h0000_0000);
      rd(`REG_IRQ_STAT_OFS, 32'h0000_0003, `RESP_OKAY);
      wr(`REG_IRQ_STAT_OFS, 32'h0000_0003, `RESP_OKAY);
      rd(`REG_IRQ_STAT_OFS, 32'h0000_0000, `RESP_OKAY);
      check({31'h0, irq}, 32'h0000_0000);
      wr(`REG_CMD_OFS, 32'h0000_0001, `RESP_OKAY);
      check({24'h0, error_count, overflow, count_complete}, 32'h0000_0000);
      $display("test reversal overflow done");

      for (int m = 0; m < 2; m++) begin
         for (int w = 1; w < 4; w++) begin
            // A ten-bit window closes before a longer burst of errors could be injected.
            e = (w == 1) ? 1 : $urandom_range(4, 1);
            n = 10 ** w;
            mode <= check_mode_t'(m);
            wr(`REG_CTRL_OFS, 32'((w << 4) | 2 | m), `RESP_OKAY);
            sync_clear();
            flip(e);
            check({26'h0, error_count}, 32'(e));
            k = 0;
            while (!count_complete && k < 50000) begin
               @(posedge aclk);
               k++;
            end
            check({31'h0, (strobes - base >= n - 2) && (strobes - base <= n + 2)}, 32'h0000_0001);
            check({26'h0, error_count}, 32'(e));
            k = 0;
            while (count_complete && k < 200) begin
               @(posedge aclk);
               k++;
            end
            check({31'h0, k >= 18 && k <= 24}, 32'h0000_0001);
            check({25'h0, error_count, overflow}, 32'h0000_0000);
            $display("test window mode=%0d exp=%0d done", m, w);
         end
      end
      stop_test();
   end

   initial begin
      #1000000;
      err_count++;
      stop_test();
   end
endmodule // bit_error_counter_tb

`default_nettype wire
